// ### verilog/i2c_link_pkg.sv
package i2c_link_pkg;

  localparam int          ADDR_W       = 7;
  localparam int          BYTE_W       = 8;
  localparam int          SEL_W        = 3;
  localparam logic [3:0]  TGT_PREFIX   = 4'hA;
  localparam logic        DIR_WRITE    = 1'b0;
  localparam logic        DIR_READ     = 1'b1;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  localparam logic [7:0]  IDLE_BYTE    = 8'hFF;
  localparam logic [7:0]  PTR_RESET    = 8'h00;

  // byte slots of one controller transfer
  localparam logic [1:0]  SLOT_ADDR_WR = 2'h0;
  localparam logic [1:0]  SLOT_PTR     = 2'h1;
  localparam logic [1:0]  SLOT_THIRD   = 2'h2;
  localparam logic [1:0]  SLOT_RDATA   = 2'h3;

  // quarter-period phases of one serial clock period
  localparam logic [1:0]  Q_SETUP      = 2'h0;
  localparam logic [1:0]  Q_RISE       = 2'h1;
  localparam logic [1:0]  Q_SAMPLE     = 2'h2;
  localparam logic [1:0]  Q_FALL       = 2'h3;

  localparam int          SYS_CLK_HZ   = 250_000_000;
  localparam int          SCL_STD_HZ   = 64_000;
  localparam int          SCL_FAST_HZ  = 400_000;
  // quarter periods round up so the link never runs faster than the mode allows
  localparam int          QTR_STD_CYC  = (SYS_CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int          QTR_FAST_CYC = (SYS_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam int          DIV_W        = 10;

endpackage

// ### verilog/i2c_link_if.sv
interface i2c_link_if;

  logic scl_o;
  logic scl_oe;
  logic sda_ctl_o;
  logic sda_ctl_oe;
  logic sda_tgt_o;
  logic sda_tgt_oe;
  logic scl;
  logic sda;

  // open-drain wires: any enabled driver pulling low wins, otherwise pulled up
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_tgt_oe && !sda_tgt_o));

  modport target (
    input  scl,
    input  sda,
    output sda_tgt_o,
    output sda_tgt_oe
  );

  modport controller (
    input  scl,
    input  sda,
    output scl_o,
    output scl_oe,
    output sda_ctl_o,
    output sda_ctl_oe
  );

endinterface

// ### verilog/i2c_target_port.sv
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - target only, never starts a transfer
// - answers address b1010 plus select pins
// - serves 64 kHz and 400 kHz clocks
// - data changes only while clock low
// - data fall/rise with clock high frame transfers
// - write opens with address and zero
// - pointer byte stored and acknowledged
// - data byte written at pointer, acknowledged
// - after write: stop or repeated start
// - pointer kept until reset or rewritten
// - read opens with address and one
// - target shifts out pointed register byte
// - after read: stop or repeated start
// - only the controller drives the clock
// - target drives data only in own slots
// - repeated start: data up, clock up, data down
module i2c_target_port (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              clk_en,
  i2c_link_if.target                             link,
  input  wire logic [i2c_link_pkg::SEL_W-1:0]    addr_sel,
  input  wire logic [i2c_link_pkg::BYTE_W-1:0]   reg_rd_data,
  output logic      [i2c_link_pkg::BYTE_W-1:0]   reg_addr,
  output logic      [i2c_link_pkg::BYTE_W-1:0]   reg_wr_data,
  output logic                                   reg_wr_en,
  output logic                                   busy
);

  typedef enum logic [3:0] {
    T_IDLE,
    T_ADDR,
    T_ACK_ADDR,
    T_PTR,
    T_ACK_PTR,
    T_WDATA,
    T_ACK_WDATA,
    T_RDATA,
    T_RACK,
    T_IGNORE
  } tgt_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: clock, data and select pins come from outside clk_sys

  logic                               scl_m_r;
  logic                               scl_s_r;
  logic                               scl_q_r;
  logic                               sda_m_r;
  logic                               sda_s_r;
  logic                               sda_q_r;
  logic [i2c_link_pkg::SEL_W-1:0]     sel_m_r;
  logic [i2c_link_pkg::SEL_W-1:0]     sel_s_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_q_r <= 1'b1;
      sel_m_r <= '0;
      sel_s_r <= '0;
    end else if (clk_en) begin
      scl_m_r <= link.scl;
      scl_s_r <= scl_m_r;
      scl_q_r <= scl_s_r;
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
      sda_q_r <= sda_s_r;
      sel_m_r <= addr_sel;
      sel_s_r <= sel_m_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // edges are taken only from the second and third stages
  assign scl_rise = scl_s_r && !scl_q_r;
  assign scl_fall = !scl_s_r && scl_q_r;
  assign start_ev = scl_s_r && scl_q_r && sda_q_r && !sda_s_r;
  assign stop_ev  = scl_s_r && scl_q_r && !sda_q_r && sda_s_r;

  ////////////////////////////////////////////////////////////////////////////////
  // protocol engine

  tgt_state_t                          state_r;
  tgt_state_t                          state_nxt;
  logic [2:0]                          cnt_r;
  logic [2:0]                          cnt_nxt;
  logic                                done_r;
  logic                                done_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     sh_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     sh_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     ptr_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     ptr_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     wdata_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     wdata_nxt;
  logic                                rw_r;
  logic                                rw_nxt;
  logic                                oe_r;
  logic                                oe_nxt;
  logic                                wr_en_r;
  logic                                wr_en_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = done_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    wdata_nxt = wdata_r;
    rw_nxt    = rw_r;
    oe_nxt    = oe_r;
    wr_en_nxt = 1'b0;
    if (stop_ev) begin
      state_nxt = T_IDLE;
      oe_nxt    = 1'b0;
    end else if (start_ev) begin
      // a repeated start restarts from the address byte, pointer untouched
      state_nxt = T_ADDR;
      cnt_nxt   = '0;
      done_nxt  = 1'b0;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        T_ADDR, T_PTR, T_WDATA: begin
          if (scl_rise) begin
            // bits are sampled on the rising clock, msb first
            sh_nxt  = {sh_r[i2c_link_pkg::BYTE_W-2:0], sda_s_r};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == i2c_link_pkg::LAST_BIT) begin
              done_nxt = 1'b1;
            end
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            case (state_r)
              T_ADDR: begin
                if (sh_r[i2c_link_pkg::BYTE_W-1:1] == {i2c_link_pkg::TGT_PREFIX, sel_s_r}) begin
                  rw_nxt    = sh_r[0];
                  oe_nxt    = 1'b1;
                  state_nxt = T_ACK_ADDR;
                end else begin
                  state_nxt = T_IGNORE;
                end
              end
              T_PTR: begin
                ptr_nxt   = sh_r;
                oe_nxt    = 1'b1;
                state_nxt = T_ACK_PTR;
              end
              default: begin
                wdata_nxt = sh_r;
                wr_en_nxt = 1'b1;
                oe_nxt    = 1'b1;
                state_nxt = T_ACK_WDATA;
              end
            endcase
          end
        end
        T_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (rw_r == i2c_link_pkg::DIR_READ) begin
              // read data comes from the stored pointer, first bit right away
              sh_nxt    = reg_rd_data;
              oe_nxt    = !reg_rd_data[i2c_link_pkg::BYTE_W-1];
              state_nxt = T_RDATA;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = T_PTR;
            end
          end
        end
        T_ACK_PTR: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            cnt_nxt   = '0;
            state_nxt = T_WDATA;
          end
        end
        T_ACK_WDATA: begin
          // one byte per transfer: later bytes are left unanswered
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            state_nxt = T_IGNORE;
          end
        end
        T_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == i2c_link_pkg::LAST_BIT) begin
              oe_nxt    = 1'b0;
              state_nxt = T_RACK;
            end else begin
              sh_nxt  = {sh_r[i2c_link_pkg::BYTE_W-2:0], 1'b0};
              oe_nxt  = !sh_r[i2c_link_pkg::BYTE_W-2];
              cnt_nxt = cnt_r + 3'h1;
            end
          end
        end
        T_RACK: begin
          // the controller's acknowledge is not needed: one byte per read
          if (scl_rise) begin
            state_nxt = T_IGNORE;
          end
        end
        T_IDLE, T_IGNORE: begin
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = T_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= T_IDLE;
      cnt_r   <= '0;
      done_r  <= 1'b0;
      sh_r    <= '0;
      ptr_r   <= i2c_link_pkg::PTR_RESET;
      wdata_r <= '0;
      rw_r    <= i2c_link_pkg::DIR_WRITE;
      oe_r    <= 1'b0;
      wr_en_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
      sh_r    <= sh_nxt;
      ptr_r   <= ptr_nxt;
      wdata_r <= wdata_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      wr_en_r <= wr_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs: only the data wire, and only ever pulled low

  assign link.sda_tgt_o  = 1'b0;
  assign link.sda_tgt_oe = oe_r;
  assign reg_addr        = ptr_r;
  assign reg_wr_data     = wdata_r;
  assign reg_wr_en       = wr_en_r;
  assign busy            = (state_r != T_IDLE) && (state_r != T_IGNORE);

endmodule

// ### verilog/i2c_controller_port.sv
////////////////////////////////////////////////////////////////////////////////
// controller end: makes the serial clock from clk_sys and sequences transfers
module i2c_controller_port #(
  parameter bit FAST_MODE = 1'b1
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              clk_en,
  i2c_link_if.controller                         link,
  input  wire logic                              cmd_valid,
  output logic                                   cmd_ready,
  input  wire logic                              cmd_read,
  input  wire logic                              cmd_use_ptr,
  input  wire logic [i2c_link_pkg::ADDR_W-1:0]   cmd_dev_addr,
  input  wire logic [i2c_link_pkg::BYTE_W-1:0]   cmd_ptr,
  input  wire logic [i2c_link_pkg::BYTE_W-1:0]   cmd_wdata,
  output logic                                   rsp_valid,
  output logic      [i2c_link_pkg::BYTE_W-1:0]   rsp_rdata,
  output logic                                   rsp_nack
);

  localparam int QTR_CYC = FAST_MODE ? i2c_link_pkg::QTR_FAST_CYC : i2c_link_pkg::QTR_STD_CYC;
  localparam logic [i2c_link_pkg::DIV_W-1:0] QTR_LAST = i2c_link_pkg::DIV_W'(QTR_CYC - 1);

  if (QTR_CYC > (1 << i2c_link_pkg::DIV_W)) begin : g_div_check
    $error("quarter period does not fit the divider");
  end

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_RSTART,
    H_STOP
  } ctl_state_t;

  logic sda_m_r;
  logic sda_s_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else if (clk_en) begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  ctl_state_t                          st_r;
  ctl_state_t                          st_nxt;
  logic [i2c_link_pkg::DIV_W-1:0]      div_r;
  logic [i2c_link_pkg::DIV_W-1:0]      div_nxt;
  logic [1:0]                          q_r;
  logic [1:0]                          q_nxt;
  logic [3:0]                          bit_r;
  logic [3:0]                          bit_nxt;
  logic [1:0]                          idx_r;
  logic [1:0]                          idx_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     sh_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     sh_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     rx_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     rx_nxt;
  logic                                scl_low_r;
  logic                                scl_low_nxt;
  logic                                sda_low_r;
  logic                                sda_low_nxt;
  logic                                rd_r;
  logic                                rd_nxt;
  logic                                nack_r;
  logic                                nack_nxt;
  logic                                rsp_v_r;
  logic                                rsp_v_nxt;
  logic [i2c_link_pkg::ADDR_W-1:0]     dev_r;
  logic [i2c_link_pkg::ADDR_W-1:0]     dev_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     ptr_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     ptr_nxt;
  logic [i2c_link_pkg::BYTE_W-1:0]     wd_r;
  logic [i2c_link_pkg::BYTE_W-1:0]     wd_nxt;

  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic rd,
                                         input logic [6:0] dev, input logic [7:0] ptr,
                                         input logic [7:0] wd);
    logic [7:0] b;
    case (idx)
      i2c_link_pkg::SLOT_ADDR_WR: b = {dev, i2c_link_pkg::DIR_WRITE};
      i2c_link_pkg::SLOT_PTR:     b = ptr;
      i2c_link_pkg::SLOT_THIRD:   b = rd ? {dev, i2c_link_pkg::DIR_READ} : wd;
      default:                    b = i2c_link_pkg::IDLE_BYTE;
    endcase
    return b;
  endfunction

  logic tick;
  logic rx_slot;
  logic last_slot;

  assign tick      = (div_r == '0);
  assign rx_slot   = (idx_r == i2c_link_pkg::SLOT_RDATA);
  assign last_slot = rd_r ? rx_slot : (idx_r == i2c_link_pkg::SLOT_THIRD);

  always_comb begin
    st_nxt      = st_r;
    div_nxt     = div_r;
    q_nxt       = q_r;
    bit_nxt     = bit_r;
    idx_nxt     = idx_r;
    sh_nxt      = sh_r;
    rx_nxt      = rx_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    rd_nxt      = rd_r;
    nack_nxt    = nack_r;
    rsp_v_nxt   = 1'b0;
    dev_nxt     = dev_r;
    ptr_nxt     = ptr_r;
    wd_nxt      = wd_r;
    if (st_r == H_IDLE) begin
      if (cmd_valid) begin
        rd_nxt   = cmd_read;
        dev_nxt  = cmd_dev_addr;
        ptr_nxt  = cmd_ptr;
        wd_nxt   = cmd_wdata;
        nack_nxt = 1'b0;
        // a read without pointer goes straight to the read address byte
        idx_nxt  = (cmd_read && !cmd_use_ptr) ? i2c_link_pkg::SLOT_THIRD
                                              : i2c_link_pkg::SLOT_ADDR_WR;
        q_nxt    = i2c_link_pkg::Q_SETUP;
        div_nxt  = QTR_LAST;
        st_nxt   = H_START;
      end
    end else if (!tick) begin
      div_nxt = div_r - 1'b1;
    end else begin
      div_nxt = QTR_LAST;
      q_nxt   = q_r + 2'h1;
      case (st_r)
        H_START: begin
          if (q_r == i2c_link_pkg::Q_SETUP) begin
            sda_low_nxt = 1'b1;
          end else begin
            scl_low_nxt = 1'b1;
            sh_nxt      = tx_byte(idx_r, rd_r, dev_r, ptr_r, wd_r);
            bit_nxt     = '0;
            q_nxt       = i2c_link_pkg::Q_SETUP;
            st_nxt      = H_BIT;
          end
        end
        H_BIT: begin
          case (q_r)
            i2c_link_pkg::Q_SETUP: begin
              // data changes only in the low half of the clock
              if (bit_r == i2c_link_pkg::ACK_SLOT) begin
                sda_low_nxt = rx_slot;
              end else begin
                sda_low_nxt = !rx_slot && !sh_r[i2c_link_pkg::BYTE_W-1];
              end
            end
            i2c_link_pkg::Q_RISE: scl_low_nxt = 1'b0;
            i2c_link_pkg::Q_SAMPLE: begin
              if (bit_r != i2c_link_pkg::ACK_SLOT) begin
                rx_nxt = {rx_r[i2c_link_pkg::BYTE_W-2:0], sda_s_r};
              end else if (!rx_slot) begin
                nack_nxt = sda_s_r;
              end
            end
            default: begin
              scl_low_nxt = 1'b1;
              if (bit_r != i2c_link_pkg::ACK_SLOT) begin
                sh_nxt  = {sh_r[i2c_link_pkg::BYTE_W-2:0], 1'b1};
                bit_nxt = bit_r + 4'h1;
              end else if (nack_r || last_slot) begin
                st_nxt = H_STOP;
              end else begin
                idx_nxt = idx_r + 2'h1;
                sh_nxt  = tx_byte(idx_r + 2'h1, rd_r, dev_r, ptr_r, wd_r);
                bit_nxt = '0;
                if (rd_r && idx_r == i2c_link_pkg::SLOT_PTR) begin
                  st_nxt = H_RSTART;
                end
              end
            end
          endcase
        end
        H_RSTART: begin
          // data up while clock low, clock up, then data down with clock high
          case (q_r)
            i2c_link_pkg::Q_SETUP:  sda_low_nxt = 1'b0;
            i2c_link_pkg::Q_RISE:   scl_low_nxt = 1'b0;
            i2c_link_pkg::Q_SAMPLE: sda_low_nxt = 1'b1;
            default: begin
              scl_low_nxt = 1'b1;
              st_nxt      = H_BIT;
            end
          endcase
        end
        H_STOP: begin
          case (q_r)
            i2c_link_pkg::Q_SETUP:  sda_low_nxt = 1'b1;
            i2c_link_pkg::Q_RISE:   scl_low_nxt = 1'b0;
            i2c_link_pkg::Q_SAMPLE: sda_low_nxt = 1'b0;
            default: begin
              rsp_v_nxt = 1'b1;
              st_nxt    = H_IDLE;
            end
          endcase
        end
        default: st_nxt = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r      <= H_IDLE;
      div_r     <= '0;
      q_r       <= '0;
      bit_r     <= '0;
      idx_r     <= '0;
      sh_r      <= '0;
      rx_r      <= '0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      rd_r      <= 1'b0;
      nack_r    <= 1'b0;
      rsp_v_r   <= 1'b0;
      dev_r     <= '0;
      ptr_r     <= '0;
      wd_r      <= '0;
    end else if (clk_en) begin
      st_r      <= st_nxt;
      div_r     <= div_nxt;
      q_r       <= q_nxt;
      bit_r     <= bit_nxt;
      idx_r     <= idx_nxt;
      sh_r      <= sh_nxt;
      rx_r      <= rx_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
      rd_r      <= rd_nxt;
      nack_r    <= nack_nxt;
      rsp_v_r   <= rsp_v_nxt;
      dev_r     <= dev_nxt;
      ptr_r     <= ptr_nxt;
      wd_r      <= wd_nxt;
    end
  end

  assign link.scl_o     = 1'b0;
  assign link.scl_oe    = scl_low_r;
  assign link.sda_ctl_o = 1'b0;
  assign link.sda_ctl_oe = sda_low_r;
  assign cmd_ready      = (st_r == H_IDLE);
  assign rsp_valid      = rsp_v_r;
  assign rsp_rdata      = rx_r;
  assign rsp_nack       = nack_r;

endmodule

// ### test/i2c_link_checker.sv
////////////////////////////////////////////////////////////////////////////////
module i2c_link_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_ctl_o,
  input wire logic sda_ctl_oe,
  input wire logic sda_tgt_o,
  input wire logic sda_tgt_oe,
  input wire logic scl,
  input wire logic sda
);
  // 625 cycles at 250 MHz is 2.5 us, the 400 kHz period; anything shorter is too fast
  localparam int MIN_PER = 625;

  logic [15:0] per_cnt_r;
  logic [15:0] per_cnt_nxt;
  logic        scl_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last clock rise, saturating so idle gaps never wrap
  always_comb begin
    per_cnt_nxt = per_cnt_r;
    if (scl && !scl_d_r) begin
      per_cnt_nxt = 16'h0001;
    end else if (per_cnt_r != 16'hFFFF) begin
      per_cnt_nxt = per_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      per_cnt_r <= 16'hFFFF;
      scl_d_r   <= 1'b1;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      scl_d_r   <= scl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence start_cond;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_cond;
    scl && $past(scl) && $rose(sda);
  endsequence

  chk_od_only: assert property (!(sda_tgt_oe && sda_tgt_o) && !(sda_ctl_oe && sda_ctl_o))
    else $error("data line driven high");
  chk_tgt_low_change: assert property ($changed(sda_tgt_oe) |-> !scl)
    else $error("target data changed while clock high");
  chk_tgt_hold: assert property ($rose(sda_tgt_oe) |-> sda_tgt_oe [*8])
    else $error("target slot too short");
  chk_tgt_sampled: assert property ($rose(sda_tgt_oe) |-> ##[1:400] $rose(scl))
    else $error("target bit not clocked");
  chk_scl_source: assert property ($changed(scl) |-> $changed(scl_oe))
    else $error("clock moved without controller");
  chk_scl_rate: assert property ($rose(scl) |-> per_cnt_r >= MIN_PER)
    else $error("clock period too short");
  chk_stop_release: assert property (stop_cond |-> !sda_tgt_oe [*4])
    else $error("target drives after stop");
  chk_start_clock: assert property (start_cond |-> ##[1:300] !scl)
    else $error("no clock after start");
endmodule

// ### test/tb_i2c_register_slave_port.sv
`define check_eq(name, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("wrong value %s expected %0h seen %0h", name, exp, got); end end

module tb_i2c_register_slave_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys, rst, cmd_valid, cmd_read, cmd_use_ptr, cmd_ready;
  logic       rsp_valid, rsp_nack, reg_wr_en, busy, scl_d, sda_d, wire_ack;
  logic [6:0] cmd_dev_addr;
  logic [7:0] cmd_ptr, cmd_wdata, rsp_rdata, reg_addr, reg_wr_data, reg_rd_data, wire_byte;
  logic [2:0] addr_sel;
  logic [8:0] wire_sh;
  logic [7:0] regs [256];
  int         miscompares, total_checks, cyc, wr_count, bit_cnt;

  i2c_link_if link ();

  i2c_target_port u_i2c_target_port (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
    .link(link.target), .addr_sel(addr_sel), .reg_rd_data(reg_rd_data),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .busy(busy));

  i2c_controller_port #(.FAST_MODE(1'b1)) u_i2c_controller_port (.clk_sys(clk_sys),
    .rst(rst), .clk_en(1'b1), .link(link.controller), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_use_ptr(cmd_use_ptr),
    .cmd_dev_addr(cmd_dev_addr), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));

  i2c_link_checker u_i2c_link_checker (.clk_sys(clk_sys), .rst(rst), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .sda_ctl_o(link.sda_ctl_o), .sda_ctl_oe(link.sda_ctl_oe),
    .sda_tgt_o(link.sda_tgt_o), .sda_tgt_oe(link.sda_tgt_oe), .scl(link.scl),
    .sda(link.sda));

  assign reg_rd_data = regs[reg_addr];

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file behind the target, plus a wire monitor that grabs the first
  // byte and its acknowledge after every start so the link can be judged alone
  // everything here is set in this one process, reset included, so each has one driver
  always @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) regs[i] <= 8'(i) ^ 8'hC3;
      wr_count  <= 0;
      bit_cnt   <= 0;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      wire_sh   <= 9'h000;
      wire_byte <= 8'h00;
      wire_ack  <= 1'b1;
    end else begin
      if (reg_wr_en === 1'b1) begin
        regs[reg_addr] <= reg_wr_data;
        wr_count <= wr_count + 1;
      end
      scl_d <= link.scl;
      sda_d <= link.sda;
      if (link.scl && scl_d && sda_d && !link.sda) begin
        bit_cnt <= 0;
      end else if (link.scl && !scl_d) begin
        wire_sh <= {wire_sh[7:0], link.sda};
        bit_cnt <= bit_cnt + 1;
        if (bit_cnt == 8) begin
          wire_byte <= wire_sh[7:0];
          wire_ack  <= link.sda;
        end
      end
    end
  end

  // five fast transfers need about 75000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic rd, input logic use_ptr, input logic [6:0] dev,
                         input logic [7:0] ptr, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge clk_sys);
    cmd_read     = rd;
    cmd_use_ptr  = use_ptr;
    cmd_dev_addr = dev;
    cmd_ptr      = ptr;
    cmd_wdata    = wd;
    cmd_valid    = 1'b1;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40000) miscompares++;
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_use_ptr = 1'b0;
    cmd_dev_addr = 7'h00;
    cmd_ptr = 8'h00;
    cmd_wdata = 8'h00;
    addr_sel = 3'h3;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    // pointer still at its reset value
    run_cmd(1'b1, 1'b0, 7'h53, 8'h00, 8'h00);
    `check_eq("rdata", 8'hC3, rsp_rdata)
    `check_eq("addr byte", 8'hA7, wire_byte)
    `check_eq("addr ack", 1'b0, wire_ack)
    run_cmd(1'b0, 1'b1, 7'h53, 8'h6D, 8'h92);
    `check_eq("nack", 1'b0, rsp_nack)
    `check_eq("pointer", 8'h6D, reg_addr)
    `check_eq("wdata", 8'h92, reg_wr_data)
    `check_eq("writes", 1, wr_count)
    `check_eq("addr byte", 8'hA6, wire_byte)
    `check_eq("busy", 1'b0, busy)
    // repeated start then read back through the pointer just sent
    run_cmd(1'b1, 1'b1, 7'h53, 8'h6D, 8'h00);
    `check_eq("rdata", 8'h92, rsp_rdata)
    `check_eq("addr byte", 8'hA7, wire_byte)
    `check_eq("writes", 1, wr_count)
    run_cmd(1'b1, 1'b0, 7'h53, 8'h00, 8'h00);
    `check_eq("rdata", 8'h92, rsp_rdata)
    // foreign address: nothing acknowledged, nothing changes
    run_cmd(1'b0, 1'b1, 7'h52, 8'h10, 8'h55);
    `check_eq("nack", 1'b1, rsp_nack)
    `check_eq("addr ack", 1'b1, wire_ack)
    `check_eq("writes", 1, wr_count)
    `check_eq("pointer", 8'h6D, reg_addr)
    finish_test();
  end
endmodule
